// File: verilog/pix_expander.sv
// Peripheral interrupt expander: 96 slots in 12 groups onto 12 CPU lines.
// Assumes synchronous one-cycle or level requests and a single-cycle register port.
`timescale 1ns/1ps
module pix_expander
    import pix_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    input  wire logic [95:0] peripheral_irq_in,
    input  wire logic        protected_write_unlock_in,
    input  wire logic        reg_wr_in,
    input  wire logic        reg_rd_in,
    input  wire logic [15:0] reg_addr_in,
    input  wire logic [15:0] reg_wdata_in,
    output logic      [15:0] reg_rdata_out,
    output logic             reg_rvalid_out,
    input  wire logic        vec_fetch_in,
    input  wire logic [3:0]  vec_group_in,
    input  wire logic        trap_in,
    input  wire logic [4:0]  trap_num_in,
    output logic      [11:0] cpu_irq_out,
    output logic             vec_valid_out,
    output logic      [11:0] vec_addr_out,
    output logic      [31:0] vec_data_out,
    output logic             expander_enabled_out
);
    typedef struct packed {
        logic        enabled;
        logic [11:0] ack;
        logic [95:0] ier;
        logic [95:0] ifr;
        logic        vec_valid;
        logic [11:0] vec_addr;
        logic [15:0] rdata;
        logic        rvalid;
    } pix_state_t;

    pix_state_t st;
    pix_state_t next_st;

    logic [95:0]          pend;
    logic [95:0]          src;
    logic [5:0]           wr_dec;
    logic [5:0]           rd_dec;
    logic                 wr_grp;
    logic                 wr_flag;
    logic [3:0]           wr_g;
    logic                 grp_ok;
    logic [3:0]           g0;
    logic [7:0]           pend_sel;
    logic [2:0]           entry;
    logic                 fetch_ok;
    logic                 trap_ok;
    logic [3:0]           trap_g0;
    logic [VEC_IDX_W-1:0] rd_idx;
    logic [15:0]          voff;
    logic                 vec_we;

    // Lowest set bit of a group's pending flags
    function automatic logic [2:0] pix_lowest(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = GROUP_SIZE - 1; i >= 0; i--)
        begin
            if (v[i])
                r = 3'(i);
        end
        return r;
    endfunction

    // Group register decode: hit, group index, flag select
    function automatic logic [5:0] pix_reg_decode(input logic [15:0] a);
        logic [15:0] off;
        off = a - GRP_BASE;
        return {off < GRP_SPAN, off[4:0]};
    endfunction

    // only requests of wired slots reach the flags
    assign src     = peripheral_irq_in & SLOT_MAP;
    assign pend    = st.ifr & st.ier;
    assign wr_dec  = pix_reg_decode(reg_addr_in);
    assign rd_dec  = wr_dec;
    assign wr_grp  = reg_wr_in && wr_dec[5];
    assign wr_flag = wr_dec[0];
    assign wr_g    = wr_dec[4:1];

    // lowest pending entry of the fetched group
    assign grp_ok   = (vec_group_in >= GRP_MIN) && (vec_group_in <= GRP_MAX);
    assign g0       = vec_group_in - GRP_MIN;
    assign pend_sel = grp_ok ? pend[8 * g0 +: 8] : 8'h00;
    assign entry    = pix_lowest(pend_sel);
    assign fetch_ok = vec_fetch_in && st.enabled && (pend_sel != 8'h00);

    // call N reads entry one of group N
    assign trap_ok  = trap_in && !fetch_ok && st.enabled
                      && (trap_num_in >= TRAP_MIN) && (trap_num_in <= TRAP_MAX);
    assign trap_g0  = 4'(trap_num_in - TRAP_MIN);
    assign rd_idx   = fetch_ok ? {g0, entry} : {trap_g0, 3'h0};

    // vector table writes only while unlocked
    assign voff   = reg_addr_in - VEC_BASE;
    assign vec_we = reg_wr_in && protected_write_unlock_in
                    && (reg_addr_in >= VEC_BASE) && (reg_addr_in <= VEC_LAST);

    always_comb
    begin
        logic [7:0]  flags;
        logic [11:0] ack_clr;
        logic [11:0] ack_set;
        flags   = 8'h00;
        ack_clr = 12'h000;
        ack_set = 12'h000;
        next_st = st;
        next_st.vec_valid = fetch_ok || trap_ok;
        next_st.rvalid    = reg_rd_in;
        if (reg_wr_in && reg_addr_in == CTRL_ADDR)
            next_st.enabled = reg_wdata_in[CTRL_EN_BIT];
        // Acknowledge: fetch blocks the group, software write of one reopens it
        if (reg_wr_in && reg_addr_in == ACK_ADDR)
            ack_clr = reg_wdata_in[11:0];
        if (fetch_ok)
            ack_set = 12'h001 << g0;
        next_st.ack = (st.ack & ~ack_clr) | ack_set;
        for (int g = 0; g < NUM_GROUPS; g++)
        begin
            if (wr_grp && !wr_flag && wr_g == 4'(g))
                next_st.ier[8 * g +: 8] = reg_wdata_in[7:0];
            flags = (wr_grp && wr_flag && wr_g == 4'(g)) ? reg_wdata_in[7:0]
                                                          : st.ifr[8 * g +: 8];
            if (fetch_ok && g0 == 4'(g))
                flags = flags & ~(8'h01 << entry);
            // a new request wins over a clear
            next_st.ifr[8 * g +: 8] = flags | src[8 * g +: 8];
        end
        // vector address of the read slot
        if (fetch_ok || trap_ok)
            next_st.vec_addr = VEC_FIRST + {4'h0, rd_idx, 1'b0};
        if (reg_rd_in)
        begin
            if (reg_addr_in == CTRL_ADDR)
                next_st.rdata = {15'h0000, st.enabled};
            else if (reg_addr_in == ACK_ADDR)
                next_st.rdata = {4'h0, st.ack};
            else if (rd_dec[5] && rd_dec[0])
                next_st.rdata = {8'h00, st.ifr[8 * rd_dec[4:1] +: 8]};
            else if (rd_dec[5])
                next_st.rdata = {8'h00, st.ier[8 * rd_dec[4:1] +: 8]};
            else
                next_st.rdata = 16'h0000;
        end
    end

    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            st <= '{CTRL_EN_RST, ACK_RST, MASK_RST, MASK_RST, 1'b0, 12'h000, 16'h0000, 1'b0};
        else if (ce_in)
            st <= next_st;
    end

    pix_vec_mem u_vec_mem (
        .sys_clk_in  (sys_clk_in),
        .rst_in      (rst_in),
        .ce_in       (ce_in),
        .wr_en_in    (vec_we),
        .wr_idx_in   (voff[7:1]),
        .wr_high_in  (voff[0]),
        .wr_data_in  (reg_wdata_in),
        .rd_en_in    (fetch_ok || trap_ok),
        .rd_idx_in   (rd_idx),
        .rd_data_out (vec_data_out)
    );

    for (genvar g = 0; g < NUM_GROUPS; g++)
    begin : g_line
        assign cpu_irq_out[g] = st.enabled && (pend[8 * g +: 8] != 8'h00) && !st.ack[g];
    end

    assign vec_valid_out        = st.vec_valid;
    assign vec_addr_out         = st.vec_addr;
    assign reg_rdata_out        = st.rdata;
    assign reg_rvalid_out       = st.rvalid;
    assign expander_enabled_out = st.enabled;

    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_fetch_taken;
        ce_in && fetch_ok;
    endsequence

    sequence s_trap_taken;
        ce_in && trap_ok;
    endsequence

    property p_irq_blocked;
        s_fetch_taken |=> !cpu_irq_out[$past(g0)];
    endproperty
    a_irq_blocked: assert property (p_irq_blocked)
        else $error("line raised while group blocked");

    property p_disabled_quiet;
        !st.enabled |-> cpu_irq_out == 12'h000 ##1 (!vec_valid_out || !$past(ce_in));
    endproperty
    a_disabled_quiet: assert property (p_disabled_quiet)
        else $error("line raised while disabled");

    property p_fetch_addr;
        s_fetch_taken |=> vec_valid_out
            && vec_addr_out == VEC_FIRST + {4'h0, $past(rd_idx), 1'b0};
    endproperty
    a_fetch_addr: assert property (p_fetch_addr)
        else $error("fetch vector address wrong");

    property p_trap_entry1;
        s_trap_taken |=> vec_valid_out
            && vec_addr_out == TRAP_BASE + 12'({$past(trap_num_in), 4'h0});
    endproperty
    a_trap_entry1: assert property (p_trap_entry1)
        else $error("call did not read entry one");

    property p_fetch_blocks;
        s_fetch_taken |=> st.ack[$past(g0)] ##1 (!ce_in || st.ack[$past(g0, 2)]
            || $past(reg_wr_in && reg_addr_in == ACK_ADDR));
    endproperty
    a_fetch_blocks: assert property (p_fetch_blocks)
        else $error("fetch did not block group");

    property p_fetch_clears;
        s_fetch_taken and (!peripheral_irq_in[{g0, entry}] && !wr_grp)
            |=> !st.ifr[$past({g0, entry})];
    endproperty
    a_fetch_clears: assert property (p_fetch_clears)
        else $error("fetched flag not cleared");

    property p_reserved_idle;
        ce_in && !reg_wr_in |=> ((st.ifr & ~$past(st.ifr)) & ~SLOT_MAP) == 96'h0;
    endproperty
    a_reserved_idle: assert property (p_reserved_idle)
        else $error("reserved slot set by hardware");

    property p_src_sets;
        ce_in |=> (st.ifr & $past(src)) == $past(src);
    endproperty
    a_src_sets: assert property (p_src_sets)
        else $error("peripheral request lost");

    property p_flag_write;
        ce_in && wr_grp && wr_flag && !fetch_ok && src == 96'h0
            |=> st.ifr[8 * $past(wr_g) +: 8] == $past(reg_wdata_in[7:0]);
    endproperty
    a_flag_write: assert property (p_flag_write)
        else $error("flag write did not overwrite group");

    property p_sw_irq;
        ce_in && wr_grp && wr_flag && st.enabled && !st.ack[wr_g] && !fetch_ok
            && (reg_wdata_in[7:0] & st.ier[8 * wr_g +: 8]) != 8'h00
            |=> cpu_irq_out[$past(wr_g)];
    endproperty
    a_sw_irq: assert property (p_sw_irq)
        else $error("software flag raised no line");

    property p_ack_read;
        ce_in && reg_rd_in && reg_addr_in == ACK_ADDR
            |=> reg_rvalid_out && reg_rdata_out == {4'h0, $past(st.ack)};
    endproperty
    a_ack_read: assert property (p_ack_read)
        else $error("acknowledge read wrong");

    property p_vec_locked;
        ce_in && reg_wr_in && !protected_write_unlock_in
            && reg_addr_in >= VEC_BASE && reg_addr_in <= VEC_LAST
            |=> u_vec_mem.mem[$past(voff[7:1])] == $past(u_vec_mem.mem[voff[7:1]]);
    endproperty
    a_vec_locked: assert property (p_vec_locked)
        else $error("vector write while locked");
endmodule

// File: verilog/pix_pkg.sv
// Constants shared by the interrupt expander and its vector memory.
// Assumes word (16-bit) register addressing on the register port.
package pix_pkg;
    localparam int            NUM_GROUPS    = 12;
    localparam int            GROUP_SIZE    = 8;
    localparam int            NUM_SLOTS     = 96;
    localparam int            VEC_DEPTH     = 96;
    localparam int            VEC_IDX_W     = 7;
    localparam logic [15:0]   CTRL_ADDR     = 16'h0ce0;
    localparam logic [15:0]   ACK_ADDR      = 16'h0ce1;
    localparam logic [15:0]   GRP_BASE      = 16'h0ce2;
    localparam logic [15:0]   GRP_SPAN      = 16'h0018;
    localparam logic [15:0]   VEC_BASE      = 16'h0d40;
    localparam logic [15:0]   VEC_LAST      = 16'h0dff;
    localparam logic [11:0]   VEC_FIRST     = 12'hd40;
    localparam logic [11:0]   TRAP_BASE     = 12'hd30;
    localparam int            CTRL_EN_BIT   = 0;
    localparam logic          CTRL_EN_RST   = 1'b0;
    localparam logic [11:0]   ACK_RST       = 12'h000;
    localparam logic [95:0]   MASK_RST      = 96'h0;
    localparam logic [4:0]    TRAP_MIN      = 5'h01;
    localparam logic [4:0]    TRAP_MAX      = 5'h0c;
    localparam logic [3:0]    GRP_MIN       = 4'h1;
    localparam logic [3:0]    GRP_MAX       = 4'hc;
    // Slots wired to a peripheral; group 12 in the top byte, group 1 in the bottom
    localparam logic [95:0]   SLOT_MAP      = 96'h0100ff0f033f3f00010303fb;
endpackage

// File: verilog/pix_vec_mem.sv
// Vector table storage: one 32-bit vector per slot, written a half at a time.
// Assumes the caller gates writes; read data come from a register.
`timescale 1ns/1ps
module pix_vec_mem
    import pix_pkg::*;
#(
    parameter int DEPTH = VEC_DEPTH,
    parameter int AW    = VEC_IDX_W
)
(
    input  wire logic          sys_clk_in,
    input  wire logic          rst_in,
    input  wire logic          ce_in,
    input  wire logic          wr_en_in,
    input  wire logic [AW-1:0] wr_idx_in,
    input  wire logic          wr_high_in,
    input  wire logic [15:0]   wr_data_in,
    input  wire logic          rd_en_in,
    input  wire logic [AW-1:0] rd_idx_in,
    output logic      [31:0]   rd_data_out
);
    logic [31:0] mem [DEPTH];

    // Storage array
    always_ff @(posedge sys_clk_in)
    begin
        if (ce_in && wr_en_in && wr_high_in)
            mem[wr_idx_in][31:16] <= wr_data_in;
        if (ce_in && wr_en_in && !wr_high_in)
            mem[wr_idx_in][15:0] <= wr_data_in;
    end

    // Registered read port
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in)
            rd_data_out <= 32'h0000_0000;
        else if (ce_in && rd_en_in)
            rd_data_out <= mem[rd_idx_in];
    end
endmodule

// File: sim/pix_cpu_model.sv
// CPU partner: answers a raised group line with a one-cycle fetch pulse.
// Assumes the expander drops a line in the cycle after its fetch is taken.
`timescale 1ns/1ps
module pix_cpu_model
    import pix_pkg::*;
(
    input  wire logic        sys_clk_in,
    input  wire logic        rst_in,
    input  wire logic        run_in,
    input  wire logic [11:0] cpu_irq_in,
    output logic             vec_fetch_out,
    output logic      [3:0]  vec_group_out
);
    logic [3:0] low_grp;

    // Lowest raised group wins the core
    always_comb
    begin
        low_grp = 4'h0;
        for (int g = NUM_GROUPS; g >= 1; g--)
        begin
            if (cpu_irq_in[g-1])
                low_grp = 4'(g);
        end
    end

    // Group number is scrambled while no fetch is requested
    always_ff @(posedge sys_clk_in)
    begin
        if (rst_in || vec_fetch_out || !run_in || low_grp == 4'h0)
        begin
            vec_fetch_out <= 1'b0;
            vec_group_out <= rst_in ? 4'hf : ~vec_group_out;
        end
        else
        begin
            vec_fetch_out <= 1'b1;
            vec_group_out <= low_grp;
        end
    end
endmodule

// File: sim/pix_expander_bench.sv
// Bench for the interrupt expander: a slot table, then hand-written cases.
// Assumes the CPU partner model takes every raised line while run is high.
`timescale 1ns/1ps
module pix_expander_bench
    import pix_pkg::*;
;
    logic        clk   = 1'b0;
    logic        rst   = 1'b1;
    logic [95:0] irq   = '0;
    logic        unlk  = 1'b0;
    logic        wr_s  = 1'b0;
    logic        rd_s  = 1'b0;
    logic [15:0] addr  = 16'h0000;
    logic [15:0] wdat  = 16'h0000;
    logic        trap  = 1'b0;
    logic [4:0]  tnum  = 5'h00;
    logic        run   = 1'b0;
    logic        ce    = 1'b1;
    logic        fetch;
    logic [3:0]  grp;
    logic [15:0] rdata;
    logic        rvalid;
    logic [11:0] cpu_irq;
    logic        vvalid;
    logic [11:0] vaddr;
    logic [31:0] vdat;
    logic        enabled;
    int          bad_count   = 0;
    int          checks_done = 0;
    localparam logic [7:0] ROWS [32] = '{8'h80, 8'h81, 8'h02, 8'h83, 8'h85, 8'h86, 8'h87,
        8'h88, 8'h89, 8'h90, 8'h91, 8'h12, 8'h98, 8'h19, 8'h20, 8'ha8, 8'had, 8'h2e, 8'hb0,
        8'hb5, 8'h36, 8'hb8, 8'hb9, 8'h3a, 8'hc0, 8'hc3, 8'h44, 8'hc8, 8'hcf, 8'h50, 8'hd8, 8'h59};

    always #2.5 clk = ~clk;

    pix_expander dut_u (.sys_clk_in(clk), .rst_in(rst), .ce_in(ce), .peripheral_irq_in(irq),
        .protected_write_unlock_in(unlk), .reg_wr_in(wr_s), .reg_rd_in(rd_s),
        .reg_addr_in(addr), .reg_wdata_in(wdat), .reg_rdata_out(rdata), .reg_rvalid_out(rvalid),
        .vec_fetch_in(fetch), .vec_group_in(grp), .trap_in(trap), .trap_num_in(tnum),
        .cpu_irq_out(cpu_irq), .vec_valid_out(vvalid), .vec_addr_out(vaddr),
        .vec_data_out(vdat), .expander_enabled_out(enabled));

    pix_cpu_model cpu_u (.sys_clk_in(clk), .rst_in(rst), .run_in(run), .cpu_irq_in(cpu_irq),
        .vec_fetch_out(fetch), .vec_group_out(grp));

    function automatic logic [31:0] vd(input int s);
        return {8'h5a, 8'(s), 8'ha5, 8'(s)};
    endfunction

    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic u);
        @(posedge clk);
        wr_s <= 1'b1;
        addr <= a;
        wdat <= d;
        unlk <= u;
        @(posedge clk);
        wr_s <= 1'b0;
        unlk <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] exp, input string name);
        @(posedge clk);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        #1;
        chk("read valid", 32'(rvalid), 32'h1);
        chk(name, 32'(rdata), 32'(exp));
    endtask

    task automatic pulse(input int s);
        @(posedge clk);
        irq[s] <= 1'b1;
        @(posedge clk);
        irq[s] <= 1'b0;
    endtask

    task automatic call(input int n);
        @(posedge clk);
        trap <= 1'b1;
        tnum <= 5'(n);
        @(posedge clk);
        trap <= 1'b0;
    endtask

    task automatic wait_vec(input logic ok, input logic [11:0] a, input logic [31:0] d);
        int i;
        #1;
        for (i = 0; i < 12 && vvalid !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
        chk("answer", 32'(i < 12), 32'(ok));
        if (ok && i < 12)
        begin
            chk("vector address", 32'(vaddr), 32'(a));
            chk("vector data", vdat, d);
        end
    endtask

    task automatic end_of_test;
        if (bad_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clk);
        bad_count++;
        end_of_test();
    end

    initial
    begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("line at reset", 32'(cpu_irq), 32'h0);
        rd(16'h0ce1, 16'h0000, "ack at reset");
        rd(16'h0cfa, 16'h0000, "unmapped");
        for (int s = 0; s < 96; s++)
        begin
            wr(16'(16'h0d40 + 2 * s), {8'ha5, 8'(s)}, 1'b1);
            wr(16'(16'h0d41 + 2 * s), {8'h5a, 8'(s)}, 1'b1);
        end
        // locked write to a vector is dropped
        wr(16'h0d4a, 16'hdead, 1'b0);
        for (int g = 0; g < 12; g++)
            wr(16'(16'h0ce2 + 2 * g), 16'h00ff, 1'b0);
        rd(16'h0ce4, 16'h00ff, "group 2 enable");
        wr(16'h0ce0, 16'h0001, 1'b0);
        run <= 1'b1;
        #1;
        chk("enabled", 32'(enabled), 32'h1);
        foreach (ROWS[r])
        begin
            pulse(int'(ROWS[r][6:0]));
            wait_vec(ROWS[r][7], 12'(12'hd40 + 2 * ROWS[r][6:0]), vd(ROWS[r][6:0]));
            wr(16'h0ce1, 16'(1 << ROWS[r][6:3]), 1'b0);
            rd(16'(16'h0ce3 + 2 * ROWS[r][6:3]), 16'h0000, "flag after fetch");
        end
        run <= 1'b0;
        pulse(6);
        pulse(7);
        #1;
        chk("group 1 line", 32'(cpu_irq), 32'h001);
        rd(16'h0ce3, 16'h00c0, "flags held");
        wr(16'h0ce3, 16'h0081, 1'b0);
        rd(16'h0ce3, 16'h0081, "flags replaced");
        run <= 1'b1;
        wait_vec(1'b1, 12'hd40, vd(0));
        wr(16'h0ce1, 16'h0001, 1'b0);
        wait_vec(1'b1, 12'hd4e, vd(7));
        wr(16'h0ce1, 16'h0001, 1'b0);
        // software interrupt in a group without peripherals
        wr(16'h0ceb, 16'h0004, 1'b0);
        wait_vec(1'b1, 12'hd84, vd(34));
        wr(16'h0ce1, 16'h0010, 1'b0);
        // Frozen clock enable drops a request
        ce <= 1'b0;
        pulse(4);
        #1;
        chk("line frozen", 32'(cpu_irq), 32'h0);
        @(posedge clk);
        ce <= 1'b1;
        rd(16'h0ce3, 16'h0000, "flag frozen");
        wait_vec(1'b0, 12'h000, 32'h0);
        // calls start at one, never zero
        for (int n = 1; n <= 13; n++)
        begin
            call(n);
            wait_vec(n <= 12, 12'(12'hd30 + 16 * n), vd(8 * (n - 1)));
        end
        wr(16'h0ce0, 16'h0000, 1'b0);
        pulse(0);
        wait_vec(1'b0, 12'h000, 32'h0);
        chk("line disabled", 32'(cpu_irq), 32'h0);
        call(1);
        wait_vec(1'b0, 12'h000, 32'h0);
        @(posedge clk);
        rst <= 1'b1;
        @(posedge clk);
        rst <= 1'b0;
        #1;
        chk("enable after reset", 32'(enabled), 32'h0);
        rd(16'h0ce3, 16'h0000, "flag after reset");
        end_of_test();
    end
endmodule
